/* File: bench/bbc_host.sv */
// Host model: drives the register port with one-cycle strobes.
// Assumes the bench calls its tasks only after reset is released.
`timescale 1ns/1ps
module bbc_host
	import bbc_pkg::*;
(
	input wire logic i_clk,
	input wire logic [15:0] i_reg_rdata,
	input wire logic i_reg_rvalid,
	output logic [7:0] o_reg_addr,
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic [15:0] o_reg_wdata
);
	// Idle port at time zero
	initial
	begin
		o_reg_addr = 8'h00;
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_wdata = 16'h0000;
	end
	// One write; released data shows its inverse so stale values never match
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (a == BBC_OFS_FAULT_CFG)
			v[7:4] = 4'h0;
		if (a == BBC_OFS_BOOST_CFG)
			v[8] = 1'b0;
		if (a == BBC_OFS_BOOST_CFG && (v[7:5] == 3'h1 || v[7:5] == 3'h2))
			v[1] = 1'b0;
		@(posedge i_clk);
		o_reg_addr <= a;
		o_reg_wdata <= v;
		o_reg_wr <= 1'b1;
		@(posedge i_clk);
		o_reg_wr <= 1'b0;
		o_reg_wdata <= ~v;
	endtask
	// One read; the answer is taken while it stands, just after the sampling edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
		@(posedge i_clk);
		o_reg_addr <= a;
		o_reg_rd <= 1'b1;
		@(posedge i_clk);
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~a;
		#1;
		d = i_reg_rdata;
		ok = i_reg_rvalid;
	endtask
	// Write, then read the same offset at the very next edge; caller keeps spare bits legal
	task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q,
		output logic ok);
		@(posedge i_clk);
		o_reg_addr <= a;
		o_reg_wdata <= d;
		o_reg_wr <= 1'b1;
		@(posedge i_clk);
		o_reg_wr <= 1'b0;
		o_reg_wdata <= ~d;
		o_reg_rd <= 1'b1;
		@(posedge i_clk);
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~a;
		#1;
		q = i_reg_rdata;
		ok = i_reg_rvalid;
	endtask
endmodule

/* File: bench/tb_top.sv */
// Bench for the configuration bank: one task per scenario, host model drives.
// Assumes the design holds its reset values after a 5-cycle reset.
`timescale 1ns/1ps
module tb_top
	import bbc_pkg::*;
;
	logic clk, rst, wr, rd, rvalid, pseudo, from_reg, smooth, gnd;
	logic [7:0] addr;
	logic [15:0] wdata, pwm, rdata, bval;
	logic [10:0] rate;
	logic [6:0] range;
	logic [9:0] slope;
	logic [2:0] dither;
	logic [3:0] shorts;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	logic [10:0] rates[4] = '{BBC_RATE_0_HZ, BBC_RATE_1_HZ, BBC_RATE_2_HZ, BBC_RATE_3_HZ};
	logic [6:0] ranges[4] = '{BBC_RANGE_0, BBC_RANGE_1, BBC_RANGE_2, BBC_RANGE_3};
	logic [9:0] lin[8] = '{10'h000, BBC_SLOPE_1_MS, BBC_SLOPE_2_MS, BBC_SLOPE_3_MS,
		BBC_SLOPE_4_MS, BBC_SLOPE_5_MS, BBC_SLOPE_6_MS, BBC_SLOPE_7_MS};
	bbc_host u_bbc_host (.i_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
		.o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));
	bbc_config_regs u_bbc_config_regs (.i_clk(clk), .i_reset(rst), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .i_pwm_brightness(pwm),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_spread_pseudo_en(pseudo),
		.o_spread_modulation_rate_hz(rate), .o_boost_oscillator_range(range),
		.o_brightness_from_reg(from_reg), .o_brightness_value(bval), .o_slope_ms(slope),
		.o_smooth_transition_enable(smooth), .o_dither_bits(dither),
		.o_string_ground_fault_enable(gnd), .o_string_short_fault_off(shorts));
	// Free-running 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Hang guard: generous next to the 160-odd cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			results();
		end
	end
	// Closing report
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Compare, widened to 16 bits so unknowns still fail
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Write, then wait the three edges the brightness path needs
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		u_bbc_host.wr(a, d);
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Read and compare, rvalid included
	task automatic get(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		u_bbc_host.rd(a, d, ok);
		chk({15'h0000, ok}, 16'h0001, "rvalid");
		chk(d, exp, "rdata");
	endtask
	// Reset values of every output but the brightness value, and of every register
	task automatic t_reset();
		chk(pseudo, 16'h0000, "pseudo");
		chk(rate, BBC_RATE_0_HZ, "rate");
		chk(range, BBC_RANGE_2, "range");
		chk(from_reg, 16'h0000, "source");
		chk(slope, BBC_RST_SLOPE_MS, "slope");
		chk(dither, 16'h0000, "dither");
		chk(smooth, 16'h0001, "smooth");
		chk(gnd, 16'h0001, "gnd");
		chk(shorts, 16'h0000, "shorts");
		get(BBC_OFS_BOOST_CFG, 16'h08A3);
		get(BBC_OFS_FAULT_CFG, 16'h0100);
		get(BBC_OFS_BRIGHTNESS, 16'h0000);
		$display("test reset done");
	endtask
	// Every rate and range code, spare bits toggled
	task automatic t_boost();
		logic [1:0] k;
		logic [15:0] w;
		for (int i = 0; i < 4; i++)
		begin
			k = i[1:0];
			w = {k[1], k[0], k, k, 2'h0, 3'h3, 3'h0, 1'b0, ~k[0]};
			put(BBC_OFS_BOOST_CFG, w);
			chk(pseudo, {15'h0000, k[0]}, "pseudo");
			chk(rate, rates[i], "rate");
			chk(range, ranges[i], "range");
			get(BBC_OFS_BOOST_CFG, w);
		end
		$display("test boost done");
	endtask
	// Every slope and dither code in linear style, codes 3 to 7 in advanced style
	task automatic t_slope();
		logic [2:0] c;
		logic [9:0] e;
		for (int i = 0; i < 16; i++)
		begin
			c = i[2:0];
			if (i < 8 || c > 3'h2)
			begin
				put(BBC_OFS_BOOST_CFG, {8'h00, c, c, i[3], 1'b1});
				e = i[3] ? lin[c] + (lin[c] >> 1) : lin[c];
				chk(slope, e, "slope");
				chk(smooth, {15'h0000, i[3]}, "smooth");
				chk(dither, (c <= BBC_DITHER_MAX) ? c : 3'h0, "dither");
			end
		end
		$display("test slope done");
	endtask
	// Brightness from register, then back to the pin
	task automatic t_source();
		put(BBC_OFS_BRIGHTNESS, 16'h1234);
		put(BBC_OFS_BOOST_CFG, 16'h0200);
		chk(from_reg, 16'h0001, "source");
		chk(bval, 16'h1234, "value");
		put(BBC_OFS_BOOST_CFG, 16'h0000);
		chk(bval, pwm, "pin");
		@(posedge clk);
		pwm <= 16'h5A5A;
		repeat (3) @(posedge clk);
		#1;
		chk(bval, 16'h5A5A, "follow");
		$display("test source done");
	endtask
	// Write then read on the next edge: the new value must already read back
	task automatic t_back();
		logic [15:0] d;
		logic ok;
		u_bbc_host.wr_rd(BBC_OFS_BOOST_CFG, 16'hC8A1, d, ok);
		chk({15'h0000, ok}, 16'h0001, "rvalid");
		chk(d, 16'hC8A1, "boost back");
		u_bbc_host.wr_rd(BBC_OFS_FAULT_CFG, 16'h0109, d, ok);
		chk({15'h0000, ok}, 16'h0001, "rvalid");
		chk(d, 16'h0109, "fault back");
		$display("test back done");
	endtask
	// Fault bits, then an unmapped write that must change nothing
	task automatic t_fault();
		logic [15:0] v[3] = '{16'hFE0F, 16'h0005, 16'h010A};
		foreach (v[i])
		begin
			put(BBC_OFS_FAULT_CFG, v[i]);
			chk(gnd, {15'h0000, v[i][8]}, "gnd");
			chk(shorts, {12'h000, v[i][3:0]}, "shorts");
			get(BBC_OFS_FAULT_CFG, v[i]);
		end
		put(8'h08, 16'hFFFF);
		get(8'h08, 16'h0000);
		get(8'h02, 16'h0000);
		get(BBC_OFS_FAULT_CFG, 16'h010A);
		$display("test fault done");
	endtask
	// Main sequence
	initial
	begin
		rst = 1'b1;
		pwm = 16'hABCD;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_boost();
		t_slope();
		t_source();
		t_back();
		t_fault();
		results();
	end
endmodule

/* File: hw/bbc_config_regs.sv */
// Backlight configuration register bank: brightness, boost and fault config.
// Assumes a 16-bit register port driven by the serial host engine.
`timescale 1ns/1ps
module bbc_config_regs
	import bbc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_wdata,
	input wire logic [15:0] i_pwm_brightness,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_spread_pseudo_en,
	output logic [10:0] o_spread_modulation_rate_hz,
	output logic [6:0] o_boost_oscillator_range,
	output logic o_brightness_from_reg,
	output logic [15:0] o_brightness_value,
	output logic [9:0] o_slope_ms,
	output logic o_smooth_transition_enable,
	output logic [2:0] o_dither_bits,
	output logic o_string_ground_fault_enable,
	output logic [3:0] o_string_short_fault_off
);
	// Stored register contents
	logic [15:0] brt_q; // brightness_value register
	logic [15:0] cfg_q; // brightness_boost_config register
	logic [15:0] flt_q; // led_fault_config register
	// Decoded write strobes
	logic wr_brt;
	logic wr_cfg;
	logic wr_flt;
	// Duration from the table, before registering
	logic [9:0] slope_nxt;
	// Field slices for readability
	logic [1:0] rate_code;
	logic [1:0] range_code;
	logic [1:0] src_code;
	logic [2:0] dither_code;

	// Address decode; unmapped writes fall on the floor
	// Full eight-bit compare, so no offset aliases onto another
	// brightness, boost and fault config decode
	always_comb
	begin
		wr_brt = i_reg_wr && (i_reg_addr == BBC_OFS_BRIGHTNESS);
		wr_cfg = i_reg_wr && (i_reg_addr == BBC_OFS_BOOST_CFG);
		wr_flt = i_reg_wr && (i_reg_addr == BBC_OFS_FAULT_CFG);
	end

	bbc_field_reg #(.W(16), .RST(BBC_RST_BRIGHTNESS)) u_brt
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_wr(wr_brt),
		.i_wdata(i_reg_wdata),
		.o_q(brt_q)
	);

	bbc_field_reg #(.W(16), .RST(BBC_RST_BOOST_CFG)) u_cfg
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_wr(wr_cfg),
		.i_wdata(i_reg_wdata),
		.o_q(cfg_q)
	);

	// bits 7-4 stored as written, host keeps them zero
	bbc_field_reg #(.W(16), .RST(BBC_RST_FAULT_CFG)) u_flt
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_wr(wr_flt),
		.i_wdata(i_reg_wdata),
		.o_q(flt_q)
	);

	// Field extraction
	always_comb
	begin
		rate_code = cfg_q[BBC_POS_RATE +: 2];
		range_code = cfg_q[BBC_POS_RANGE +: 2];
		src_code = cfg_q[BBC_POS_SOURCE +: 2];
		dither_code = cfg_q[BBC_POS_DITHER +: 3];
	end

	bbc_slope_decode u_slope
	(
		.i_code(cfg_q[BBC_POS_SLOPE +: 3]),
		.i_smooth(cfg_q[BBC_POS_SMOOTH]),
		.o_ms(slope_nxt)
	);

	// Read port: one cycle latency, unmapped offsets read as zero
	// A read that meets a write to the same offset returns the old contents
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_reg_rdata <= 16'h0000;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
			begin
				unique case (i_reg_addr)
					BBC_OFS_BRIGHTNESS: o_reg_rdata <= brt_q;
					BBC_OFS_BOOST_CFG: o_reg_rdata <= cfg_q;
					BBC_OFS_FAULT_CFG: o_reg_rdata <= flt_q;
					default: o_reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Boost spread-spectrum controls
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_spread_pseudo_en <= BBC_RST_BOOST_CFG[BBC_POS_PSEUDO];
			o_spread_modulation_rate_hz <= BBC_RST_RATE_HZ;
			o_boost_oscillator_range <= BBC_RST_RANGE;
		end
		else
		begin
			o_spread_pseudo_en <= cfg_q[BBC_POS_PSEUDO];
			unique case (rate_code)
				2'h0: o_spread_modulation_rate_hz <= BBC_RATE_0_HZ;
				2'h1: o_spread_modulation_rate_hz <= BBC_RATE_1_HZ;
				2'h2: o_spread_modulation_rate_hz <= BBC_RATE_2_HZ;
				2'h3: o_spread_modulation_rate_hz <= BBC_RATE_3_HZ;
			endcase
			unique case (range_code)
				2'h0: o_boost_oscillator_range <= BBC_RANGE_0;
				2'h1: o_boost_oscillator_range <= BBC_RANGE_1;
				2'h2: o_boost_oscillator_range <= BBC_RANGE_2;
				2'h3: o_boost_oscillator_range <= BBC_RANGE_3;
			endcase
		end
	end

	// Brightness path: the source is registered first, so the mux uses a stable select
	// The price is one more cycle before the value follows a source change
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_brightness_from_reg <= 1'b0;
			o_brightness_value <= 16'h0000;
		end
		else
		begin
			// reserved codes fall back to the PWM pin
			o_brightness_from_reg <= (src_code == BBC_SRC_REG);
			o_brightness_value <= o_brightness_from_reg ? brt_q : i_pwm_brightness;
		end
	end

	// Sloper and dither settings
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_slope_ms <= BBC_RST_SLOPE_MS;
			o_smooth_transition_enable <= BBC_RST_BOOST_CFG[BBC_POS_SMOOTH];
			o_dither_bits <= BBC_RST_BOOST_CFG[BBC_POS_DITHER +: 3];
		end
		else
		begin
			o_slope_ms <= slope_nxt;
			o_smooth_transition_enable <= cfg_q[BBC_POS_SMOOTH];
			// codes above four are not defined, treated as off
			o_dither_bits <= (dither_code > BBC_DITHER_MAX) ? 3'h0 : dither_code;
		end
	end

	// Fault detector controls
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_string_ground_fault_enable <= BBC_RST_FAULT_CFG[BBC_POS_GND];
			o_string_short_fault_off <= BBC_RST_FAULT_CFG[BBC_POS_SHORT +: 4];
		end
		else
		begin
			o_string_ground_fault_enable <= flt_q[BBC_POS_GND];
			o_string_short_fault_off <= flt_q[BBC_POS_SHORT +: 4];
		end
	end

	// Checks: a write reaches the decoded outputs two edges later
	a_pseudo_follow: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg |-> ##2 o_spread_pseudo_en == $past(i_reg_wdata[14], 2))
		else $error("pseudo-random enable did not follow bit 14");
	a_rate_fastest: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg && i_reg_wdata[13:12] == 2'h3 ##1 !wr_cfg |-> ##1 o_spread_modulation_rate_hz == 11'h4B0)
		else $error("rate code 3 did not give 1200 Hz");
	a_range_widest: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg && i_reg_wdata[11:10] == 2'h3 ##1 !wr_cfg |-> ##1 o_boost_oscillator_range == 7'h48)
		else $error("range code 3 did not give 7.2 percent");
	a_source_reg: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg ##1 !wr_cfg |-> ##1 o_brightness_from_reg == ($past(i_reg_wdata[9:8], 2) == 2'h2))
		else $error("brightness source decode wrong");
	a_slope_linear: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg && i_reg_wdata[7:5] == 3'h7 && !i_reg_wdata[1] ##1 !wr_cfg
		|-> ##1 o_slope_ms == 10'h1F4)
		else $error("linear 500 ms code decoded wrong");
	a_slope_smooth: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg && i_reg_wdata[7:5] == 3'h3 && i_reg_wdata[1] ##1 !wr_cfg
		|-> ##1 o_slope_ms == 10'h04B && o_smooth_transition_enable)
		else $error("advanced 50 ms code not stretched");
	a_slope_both: assert property (@(posedge i_clk) disable iff (i_reset)
		o_slope_ms != 10'h000 |-> $past(cfg_q[7:5], 1) != 3'h0)
		else $error("duration present while sloping disabled");
	a_dither_depth: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg && i_reg_wdata[4:2] == 3'h4 ##1 !wr_cfg |-> ##1 o_dither_bits == 3'h4)
		else $error("4-bit dither not selected");
	a_style_bit: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg ##1 !wr_cfg |-> ##1 o_smooth_transition_enable == $past(i_reg_wdata[1], 2))
		else $error("sloping style did not follow bit 1");
	a_cfg_readback: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg ##1 (i_reg_rd && i_reg_addr == 8'h04 && !i_reg_wr)
		|=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("boost config did not read back as written");
	a_flt_readback: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_flt ##1 (i_reg_rd && i_reg_addr == 8'h06 && !i_reg_wr)
		|=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("fault config did not read back as written");
	a_gnd_follow: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_flt |-> ##2 o_string_ground_fault_enable == $past(i_reg_wdata[8], 2))
		else $error("ground detect enable did not follow bit 8");
	a_short_follow: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_flt |-> ##2 o_string_short_fault_off == $past(i_reg_wdata[3:0], 2))
		else $error("short fault suppression did not follow bits 3-0");
	a_brt_select: assert property (@(posedge i_clk) disable iff (i_reset)
		o_brightness_from_reg |=> o_brightness_value == $past(brt_q, 1))
		else $error("register brightness not passed through");
	a_reset_boost: assert property (@(posedge i_clk)
		$fell(i_reset) |-> cfg_q == 16'h08A3)
		else $error("boost config reset value wrong");
	// Reset contents seen on the first edge after release, and the unmapped read path
	a_reset_fault: assert property (@(posedge i_clk)
		$fell(i_reset) |-> flt_q == 16'h0100)
		else $error("fault config reset value wrong");
	a_reset_slope: assert property (@(posedge i_clk)
		$fell(i_reset) |-> o_slope_ms == 10'h12C && o_smooth_transition_enable)
		else $error("sloper reset settings wrong");
	a_unmapped_zero: assert property (@(posedge i_clk) disable iff (i_reset)
		i_reg_rd && i_reg_addr != 8'h00 && i_reg_addr != 8'h04 && i_reg_addr != 8'h06
		|=> o_reg_rvalid && o_reg_rdata == 16'h0000)
		else $error("unmapped offset did not read as zero");

	// Main scenarios
	c_reg_source: cover property (@(posedge i_clk) disable iff (i_reset)
		wr_cfg && i_reg_wdata[9:8] == 2'h2);
	c_smooth_long: cover property (@(posedge i_clk) disable iff (i_reset)
		o_smooth_transition_enable && o_slope_ms == 10'h2EE);
	c_all_shorts_off: cover property (@(posedge i_clk) disable iff (i_reset)
		o_string_short_fault_off == 4'hF && !o_string_ground_fault_enable);
	c_unmapped_read: cover property (@(posedge i_clk) disable iff (i_reset)
		i_reg_rd && i_reg_addr == 8'h02);
	c_back_to_back: cover property (@(posedge i_clk) disable iff (i_reset)
		wr_flt ##1 i_reg_rd && i_reg_addr == 8'h06);
endmodule

/* File: hw/bbc_field_reg.sv */
// One read/write storage register with a fixed reset value.
// Assumes the write strobe is already decoded for this register.
`timescale 1ns/1ps
module bbc_field_reg
#(
	parameter int W = 16,
	parameter logic [W-1:0] RST = '0
)
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_wr,
	input wire logic [W-1:0] i_wdata,
	output logic [W-1:0] o_q
);
	// Plain storage; every bit, reserved or not, reads back as written
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_q <= RST;
		end
		else if (i_wr)
		begin
			o_q <= i_wdata;
		end
	end
endmodule

/* File: hw/bbc_pkg.sv */
// Constants for the backlight configuration register bank.
// Assumes a 16-bit register port behind the serial host interface.
package bbc_pkg;
	// Register offsets as printed
	localparam logic [7:0] BBC_OFS_BRIGHTNESS = 8'h00;
	localparam logic [7:0] BBC_OFS_BOOST_CFG = 8'h04;
	localparam logic [7:0] BBC_OFS_FAULT_CFG = 8'h06;
	// Reset values
	localparam logic [15:0] BBC_RST_BRIGHTNESS = 16'h0000;
	localparam logic [15:0] BBC_RST_BOOST_CFG = 16'h08A3;
	localparam logic [15:0] BBC_RST_FAULT_CFG = 16'h0100;
	// Field positions in brightness_boost_config
	localparam int BBC_POS_PSEUDO = 14;
	localparam int BBC_POS_RATE = 12;
	localparam int BBC_POS_RANGE = 10;
	localparam int BBC_POS_SOURCE = 8;
	localparam int BBC_POS_SLOPE = 5;
	localparam int BBC_POS_DITHER = 2;
	localparam int BBC_POS_SMOOTH = 1;
	// Field positions in led_fault_config
	localparam int BBC_POS_GND = 8;
	localparam int BBC_POS_SHORT = 0;
	// Brightness source codes
	localparam logic [1:0] BBC_SRC_PWM = 2'h0;
	localparam logic [1:0] BBC_SRC_REG = 2'h2;
	// Modulation rates in Hz
	localparam logic [10:0] BBC_RATE_0_HZ = 11'h0C8;
	localparam logic [10:0] BBC_RATE_1_HZ = 11'h1F4;
	localparam logic [10:0] BBC_RATE_2_HZ = 11'h320;
	localparam logic [10:0] BBC_RATE_3_HZ = 11'h4B0;
	// Spread ranges in tenths of a percent
	localparam logic [6:0] BBC_RANGE_0 = 7'h21;
	localparam logic [6:0] BBC_RANGE_1 = 7'h2B;
	localparam logic [6:0] BBC_RANGE_2 = 7'h35;
	localparam logic [6:0] BBC_RANGE_3 = 7'h48;
	// Linear transition durations in ms
	localparam logic [9:0] BBC_SLOPE_1_MS = 10'h001;
	localparam logic [9:0] BBC_SLOPE_2_MS = 10'h002;
	localparam logic [9:0] BBC_SLOPE_3_MS = 10'h032;
	localparam logic [9:0] BBC_SLOPE_4_MS = 10'h064;
	localparam logic [9:0] BBC_SLOPE_5_MS = 10'h0C8;
	localparam logic [9:0] BBC_SLOPE_6_MS = 10'h12C;
	localparam logic [9:0] BBC_SLOPE_7_MS = 10'h1F4;
	// Deepest dither setting
	localparam logic [2:0] BBC_DITHER_MAX = 3'h4;
	// Decoded values that match the reset register contents
	localparam logic [10:0] BBC_RST_RATE_HZ = BBC_RATE_0_HZ;
	localparam logic [6:0] BBC_RST_RANGE = BBC_RANGE_2;
	localparam logic [9:0] BBC_RST_SLOPE_MS = 10'h12C;
endpackage

/* File: hw/bbc_slope_decode.sv */
// Maps the transition code and sloping style to a duration in ms.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module bbc_slope_decode
	import bbc_pkg::*;
(
	input wire logic [2:0] i_code,
	input wire logic i_smooth,
	output logic [9:0] o_ms
);
	logic [9:0] base;
	// Linear duration table
	always_comb
	begin
		unique case (i_code)
			3'h0: base = 10'h000;
			3'h1: base = BBC_SLOPE_1_MS;
			3'h2: base = BBC_SLOPE_2_MS;
			3'h3: base = BBC_SLOPE_3_MS;
			3'h4: base = BBC_SLOPE_4_MS;
			3'h5: base = BBC_SLOPE_5_MS;
			3'h6: base = BBC_SLOPE_6_MS;
			3'h7: base = BBC_SLOPE_7_MS;
		endcase
	end
	// Advanced style stretches by half again; 500 ms becomes 750 ms, still fits
	always_comb
	begin
		o_ms = i_smooth ? 10'(base + (base >> 1)) : base;
	end
endmodule
